// file: core/intc_pkg.sv
/*
  Constants for the interrupt vector and hardware trap logic: register
  map, field positions, reset values, trap numbers and node layout.
  Assumes one 10 MHz core clock and a 16-bit register port.
*/
package intc_pkg;

  localparam int NODE_CNT = 80;
  localparam logic [6:0] NODE_BASE_TRAP = 7'h10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_SEG_ADDR = 8'h80;
  localparam logic [7:0] CPU_CFG_ADDR = 8'h81;
  localparam logic [7:0] TRAP_FLAG_ADDR = 8'h82;
  localparam logic [7:0] STATUS_ADDR = 8'h83;

  localparam int CTRL_LVL_LSB = 2;
  localparam int CTRL_IE_BIT = 6;
  localparam int CTRL_IR_BIT = 7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VEC_SEG_RESET = 8'h00;
  localparam logic [1:0] SPACING_RESET = 2'h0;
  localparam logic [7:0] TRAP_FLAG_RESET = 8'h00;
  localparam int SPACING_BASE_SHIFT = 2;

  // ----------------------------------------------------------------
  // Trap numbers and priorities
  // ----------------------------------------------------------------
  localparam logic [6:0] EOT_TRAP_NUM = 7'h4c;
  localparam logic [15:0] EOT_VEC_OFFSET = 16'h0130;
  localparam logic [6:0] TRAP_NUM_NMI = 7'h02;
  localparam logic [6:0] TRAP_NUM_STACK_OVER = 7'h04;
  localparam logic [6:0] TRAP_NUM_STACK_UNDER = 7'h06;
  localparam logic [6:0] TRAP_NUM_SOFT_BREAK = 7'h08;
  localparam logic [6:0] TRAP_NUM_CLASS_B = 7'h0a;
  localparam logic [1:0] TRAP_PRI_A = 2'h2;
  localparam logic [1:0] TRAP_PRI_B = 2'h1;

  // Nodes indexed by trap number minus NODE_BASE_TRAP
  localparam logic [79:0] UNASSIGNED_MASK = (80'h1 << 8'h2f)
    | (80'h1 << 8'h30) | (80'h1 << 8'h31) | (80'h1 << 8'h3b)
    | (80'h1 << 8'h48);

endpackage

// file: core/intc_prio_select.sv
/*
  Priority selector: picks the pending enabled node with the highest
  level, lowest index on a tie. Inputs come from flops on the same clock.
*/
`timescale 1ns/100ps
module intc_prio_select (
  input wire logic [79:0] req_i,
  input wire logic [319:0] lvl_i,
  output logic valid_o,
  output logic [6:0] idx_o,
  output logic [3:0] lvl_o
);

  // ------------------------------------------------------------
  // Linear search, scanning down so lower indices win ties
  // ------------------------------------------------------------
  always_comb begin
    valid_o = 1'b0;
    idx_o = 7'h00;
    lvl_o = 4'h0;
    for (int i = 79; i >= 0; i--) begin
      if (req_i[i] && (!valid_o || lvl_i[i*4 +: 4] >= lvl_o)) begin
        valid_o = 1'b1;
        idx_o = 7'(i);
        lvl_o = lvl_i[i*4 +: 4];
      end
    end
  end

endmodule // intc_prio_select

// file: core/intc_vector_core.sv
/*
  Interrupt node registers, hardware trap flags, arbitration and vector
  forming. Peripheral and trap event pulses come from logic on the same
  clock; the CPU accepts a request with int_ack_i and ends a service
  with int_ret_i.
*/
`timescale 1ns/100ps
module intc_vector_core (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o,
  input wire logic [79:0] periph_req_i,
  input wire logic [7:0] trap_evt_i,
  output logic int_req_o,
  output logic int_is_trap_o,
  output logic [6:0] int_trap_num_o,
  output logic [3:0] int_level_o,
  output logic [23:0] int_vector_o,
  input wire logic int_ack_i,
  input wire logic int_ret_i
);

  logic [7:0] node_ctrl [80];
  logic [7:0] vector_segment_select;
  logic [1:0] vector_spacing_field;
  logic [7:0] trap_flag_register;
  logic [4:0] trap_pend;
  logic [15:0] lvl_act;
  logic [1:0] trap_act;
  logic [79:0] node_req;
  logic [319:0] node_lvl;
  logic [79:0] clr_node;
  logic win_valid;
  logic [6:0] win_idx;
  logic [3:0] win_lvl;
  logic [3:0] cur_level;
  logic [1:0] trap_cur;
  logic [2:0] trap_sel;
  logic trap_sel_valid;
  logic [1:0] trap_sel_pri;
  logic [6:0] trap_sel_num;
  logic [2:0] taken_trap;
  logic [6:0] taken_node;
  logic take;
  logic [6:0] next_num;
  logic [23:0] next_vector;

  assign take = int_req_o && int_ack_i;

  // ------------------------------------------------------------
  // Node control registers
  // ------------------------------------------------------------
  for (genvar n = 0; n < intc_pkg::NODE_CNT; n++) begin : g_node
    logic hw_set;
    assign hw_set = periph_req_i[n] && !intc_pkg::UNASSIGNED_MASK[n];
    assign clr_node[n] = take && !int_is_trap_o && taken_node == 7'(n);
    assign node_req[n] = node_ctrl[n][intc_pkg::CTRL_IR_BIT]
                       && node_ctrl[n][intc_pkg::CTRL_IE_BIT];
    assign node_lvl[n*4 +: 4] = node_ctrl[n][intc_pkg::CTRL_LVL_LSB +: 4];
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        node_ctrl[n] <= intc_pkg::CTRL_RESET;
      end else if (we_i && addr_i == 8'(n)) begin
        // Hardware set wins over a software clear
        node_ctrl[n] <= {wdata_i[intc_pkg::CTRL_IR_BIT] | hw_set,
                         wdata_i[intc_pkg::CTRL_IE_BIT],
                         wdata_i[intc_pkg::CTRL_LVL_LSB +: 4], 2'b00};
      end else if (hw_set) begin
        node_ctrl[n][intc_pkg::CTRL_IR_BIT] <= 1'b1;
      end else if (clr_node[n]) begin
        node_ctrl[n][intc_pkg::CTRL_IR_BIT] <= 1'b0;
      end
    end
  end

  intc_prio_select u_sel (
    .req_i(node_req),
    .lvl_i(node_lvl),
    .valid_o(win_valid),
    .idx_o(win_idx),
    .lvl_o(win_lvl)
  );

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vector_segment_select <= intc_pkg::VEC_SEG_RESET;
      vector_spacing_field <= intc_pkg::SPACING_RESET;
    end else if (we_i) begin
      if (addr_i == intc_pkg::VEC_SEG_ADDR) begin
        vector_segment_select <= wdata_i[7:0];
      end
      if (addr_i == intc_pkg::CPU_CFG_ADDR) begin
        vector_spacing_field <= wdata_i[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Trap flags and pending traps
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trap_flag_register <= intc_pkg::TRAP_FLAG_RESET;
    end else if (we_i && addr_i == intc_pkg::TRAP_FLAG_ADDR) begin
      trap_flag_register <= wdata_i[7:0] | trap_evt_i;
    end else begin
      trap_flag_register <= trap_flag_register | trap_evt_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trap_pend <= 5'h00;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if ((k < 4) ? trap_evt_i[k] : |trap_evt_i[7:4]) begin
          trap_pend[k] <= 1'b1;
        end else if (take && int_is_trap_o && taken_trap == 3'(k)) begin
          trap_pend[k] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    trap_sel_valid = |trap_pend;
    trap_sel = 3'h4;
    for (int k = 3; k >= 0; k--) begin
      if (trap_pend[k]) begin
        trap_sel = 3'(k);
      end
    end
    trap_sel_pri = (trap_sel == 3'h4) ? intc_pkg::TRAP_PRI_B
                                      : intc_pkg::TRAP_PRI_A;
    unique case (trap_sel)
      3'h0: trap_sel_num = intc_pkg::TRAP_NUM_NMI;
      3'h1: trap_sel_num = intc_pkg::TRAP_NUM_STACK_OVER;
      3'h2: trap_sel_num = intc_pkg::TRAP_NUM_STACK_UNDER;
      3'h3: trap_sel_num = intc_pkg::TRAP_NUM_SOFT_BREAK;
      default: trap_sel_num = intc_pkg::TRAP_NUM_CLASS_B;
    endcase
  end

  // ------------------------------------------------------------
  // Service nesting: active interrupt levels and trap classes
  // ------------------------------------------------------------
  always_comb begin
    cur_level = 4'h0;
    for (int l = 1; l < 16; l++) begin
      if (lvl_act[l]) begin
        cur_level = 4'(l);
      end
    end
    trap_cur = trap_act[1] ? intc_pkg::TRAP_PRI_A
             : (trap_act[0] ? intc_pkg::TRAP_PRI_B : 2'h0);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lvl_act <= 16'h0000;
      trap_act <= 2'h0;
    end else if (take && int_is_trap_o) begin
      trap_act[trap_sel_pri_q()] <= 1'b1;
    end else if (take) begin
      lvl_act[int_level_o] <= 1'b1;
    end else if (int_ret_i) begin
      // Innermost service ends first; traps always nest on top
      if (trap_act[0] && !trap_act[1]) begin
        trap_act[0] <= 1'b0;
      end else if (trap_act[1]) begin
        trap_act[1] <= 1'b0;
      end else begin
        lvl_act[cur_level] <= 1'b0;
      end
    end
  end

  function automatic logic trap_sel_pri_q();
    trap_sel_pri_q = (taken_trap != 3'h4);
  endfunction

  // ------------------------------------------------------------
  // Request presented to the CPU
  // ------------------------------------------------------------
  assign next_num = (trap_sel_valid && trap_sel_pri > trap_cur)
                  ? trap_sel_num : intc_pkg::NODE_BASE_TRAP + win_idx;
  assign next_vector = {vector_segment_select, 16'h0000}
    + 24'({17'h00000, next_num}
          << (intc_pkg::SPACING_BASE_SHIFT + 32'(vector_spacing_field)));

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_req_o <= 1'b0;
      int_is_trap_o <= 1'b0;
      int_trap_num_o <= 7'h00;
      int_level_o <= 4'h0;
      int_vector_o <= 24'h000000;
      taken_trap <= 3'h0;
      taken_node <= 7'h00;
    end else begin
      int_trap_num_o <= next_num;
      int_vector_o <= next_vector;
      taken_trap <= trap_sel;
      taken_node <= win_idx;
      int_level_o <= win_lvl;
      if (take || int_ret_i) begin
        int_req_o <= 1'b0;
        int_is_trap_o <= 1'b0;
      end else if (trap_sel_valid && trap_sel_pri > trap_cur) begin
        int_req_o <= 1'b1;
        int_is_trap_o <= 1'b1;
      end else begin
        // Trap service blocks ordinary requests
        int_req_o <= win_valid && win_lvl > cur_level && trap_act == 2'h0;
        int_is_trap_o <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (re_i) begin
      if (addr_i < 8'(intc_pkg::NODE_CNT)) begin
        rdata_o <= {8'h00, node_ctrl[7'(addr_i)]};
      end else if (addr_i == intc_pkg::VEC_SEG_ADDR) begin
        rdata_o <= {8'h00, vector_segment_select};
      end else if (addr_i == intc_pkg::CPU_CFG_ADDR) begin
        rdata_o <= {14'h0000, vector_spacing_field};
      end else if (addr_i == intc_pkg::TRAP_FLAG_ADDR) begin
        rdata_o <= {8'h00, trap_flag_register};
      end else if (addr_i == intc_pkg::STATUS_ADDR) begin
        rdata_o <= {10'h000, trap_act, cur_level};
      end else begin
        rdata_o <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_vec_form;
    @(posedge core_clk_i) disable iff (!resetn_i)
    // Vector output lags the configuration registers by one cycle
    int_req_o |-> int_vector_o == {$past(vector_segment_select), 16'h0000}
      + 24'({17'h00000, int_trap_num_o}
            << (intc_pkg::SPACING_BASE_SHIFT + $past(vector_spacing_field)));
  endproperty
  a_vec_form: assert property (p_vec_form)
    else $error("vector address not segment plus scaled trap");

  property p_default_step;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (int_req_o && $past(vector_spacing_field) == 2'h0
      && $stable(int_trap_num_o))
      |-> int_vector_o[15:0] == {7'h00, int_trap_num_o, 2'b00};
  endproperty
  a_default_step: assert property (p_default_step)
    else $error("default spacing is not four bytes");

  property p_eot_vec;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (int_req_o && !int_is_trap_o && int_trap_num_o == intc_pkg::EOT_TRAP_NUM
      && $past(vector_spacing_field) == 2'h0)
      |-> int_vector_o[15:0] == intc_pkg::EOT_VEC_OFFSET;
  endproperty
  a_eot_vec: assert property (p_eot_vec)
    else $error("end of transfer vector offset wrong");

  property p_flag_set;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (|trap_evt_i) |=> (trap_flag_register & $past(trap_evt_i))
      == $past(trap_evt_i);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("trap flag not set by trap event");

  property p_trap_block;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (trap_act != 2'h0) |-> !(int_req_o && !int_is_trap_o);
  endproperty
  a_trap_block: assert property (p_trap_block)
    else $error("ordinary request offered during trap service");

  property p_nest_level;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (int_req_o && !int_is_trap_o) |-> int_level_o > cur_level;
  endproperty
  a_nest_level: assert property (p_nest_level)
    else $error("request offered without higher level");

  property p_trap_preempt;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (int_req_o && int_is_trap_o) |->
      (taken_trap == 3'h4 ? intc_pkg::TRAP_PRI_B : intc_pkg::TRAP_PRI_A)
        > trap_cur;
  endproperty
  a_trap_preempt: assert property (p_trap_preempt)
    else $error("trap offered over higher trap service");

  property p_nmi_branch;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (trap_evt_i[0] && trap_act == 2'h0 && !int_ack_i && !int_ret_i)
      ##1 (!int_ack_i && !int_ret_i)
      |=> int_req_o && int_is_trap_o
          && int_trap_num_o == intc_pkg::TRAP_NUM_NMI;
  endproperty
  a_nmi_branch: assert property (p_nmi_branch)
    else $error("non-maskable trap not offered in time");

  property p_sw_request;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (we_i && addr_i < 8'(intc_pkg::NODE_CNT) && wdata_i[7])
      |=> node_ctrl[7'($past(addr_i))][intc_pkg::CTRL_IR_BIT];
  endproperty
  a_sw_request: assert property (p_sw_request)
    else $error("software request bit not stored");

  c_int_take: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    take && !int_is_trap_o);
  c_trap_take: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    take && int_is_trap_o);
  c_nested: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    take && !int_is_trap_o && cur_level != 4'h0);

endmodule // intc_vector_core

// file: bench/cpu_partner.sv
/*
  CPU-side partner: accepts offered requests after a chosen delay and
  records what it took; passes service-end commands on.
  Assumes the core clock and active-low reset of the block under test.
*/
`timescale 1ns/100ps
module cpu_partner (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic int_req_i,
  input wire logic int_is_trap_i,
  input wire logic [6:0] int_trap_num_i,
  input wire logic [23:0] int_vector_i,
  input wire logic ack_en_i,
  input wire logic [1:0] ack_delay_i,
  input wire logic ret_cmd_i,
  output logic int_ack_o,
  output logic int_ret_o,
  output logic [31:0] taken_o,
  output logic [7:0] taken_cnt_o
);
  logic [1:0] wait_cnt;

  assign int_ret_o = ret_cmd_i;

  // Acknowledge is held until sampled together with a request
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      taken_o <= 32'h00000000;
      taken_cnt_o <= 8'h00;
    end else if (int_ack_o) begin
      if (int_req_i) begin
        int_ack_o <= 1'b0;
        taken_o <= {int_is_trap_i, int_trap_num_i, int_vector_i};
        taken_cnt_o <= taken_cnt_o + 8'h01;
      end
    end else if (int_req_i && ack_en_i) begin
      if (wait_cnt >= ack_delay_i) begin
        int_ack_o <= 1'b1;
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end else begin
      wait_cnt <= 2'h0;
    end
  end
endmodule // cpu_partner

// file: bench/tb_intc_vector_core.sv
/*
  Self-checking bench for the vector and trap logic: node table,
  segment and spacing, priorities, hardware traps and their flags.
  Assumes cpu_partner answers on the CPU side.
*/
`timescale 1ns/100ps
module tb_intc_vector_core;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [79:0] periph_req_i = '0;
  logic [7:0] trap_evt_i = 8'h00;
  logic [15:0] rdata_o;
  logic int_req_o, int_is_trap_o, int_ack_i, int_ret_i;
  logic [6:0] int_trap_num_o;
  logic [3:0] int_level_o;
  logic [23:0] int_vector_o;
  logic ack_en = 1'b1;
  logic [1:0] ack_delay = 2'h0;
  logic ret_cmd = 1'b0;
  logic [31:0] taken;
  logic [7:0] taken_cnt;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] rng = 32'd93017;
  logic [7:0] seg = 8'h00;
  logic [1:0] sp = 2'h0;
  logic [6:0] ix;
  logic [3:0] la, lb;
  logic [6:0] tbl_num [8] = '{7'h20, 7'h4c, 7'h5d, 7'h10, 7'h47,
                              7'h3f, 7'h58, 7'h4b};
  logic [15:0] tbl_vec [8] = '{16'h0080, 16'h0130, 16'h0174, 16'h0040,
                               16'h011c, 16'h00fc, 16'h0160, 16'h012c};

  always #50 core_clk_i = ~core_clk_i;

  intc_vector_core intc_vector_core_i (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .periph_req_i(periph_req_i),
    .trap_evt_i(trap_evt_i), .int_req_o(int_req_o),
    .int_is_trap_o(int_is_trap_o), .int_trap_num_o(int_trap_num_o),
    .int_level_o(int_level_o), .int_vector_o(int_vector_o),
    .int_ack_i(int_ack_i), .int_ret_i(int_ret_i));

  cpu_partner cpu_partner_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .int_req_i(int_req_o), .int_is_trap_i(int_is_trap_o),
    .int_trap_num_i(int_trap_num_o), .int_vector_i(int_vector_o),
    .ack_en_i(ack_en), .ack_delay_i(ack_delay), .ret_cmd_i(ret_cmd),
    .int_ack_o(int_ack_i), .int_ret_o(int_ret_i), .taken_o(taken),
    .taken_cnt_o(taken_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Expected take: segment base plus trap number scaled by spacing
  function automatic logic [31:0] exp_tk(logic t, logic [6:0] n);
    return {t, n, {seg, 16'h0000} + (24'(n) << (2 + sp))};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge core_clk_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge core_clk_i);
    re_i <= 1'b0;
    @(negedge core_clk_i);
    chk(32'(rdata_o), exp);
  endtask

  task automatic evt(input logic [79:0] p, input logic [7:0] t);
    @(posedge core_clk_i);
    periph_req_i <= p;
    trap_evt_i <= t;
    @(posedge core_clk_i);
    periph_req_i <= '0;
    trap_evt_i <= 8'h00;
  endtask

  task automatic take(input logic t, input logic [6:0] n);
    logic [7:0] c;
    int k;
    c = taken_cnt;
    k = 0;
    while (taken_cnt === c && k < 20) begin
      @(negedge core_clk_i);
      k++;
    end
    chk(32'(taken_cnt), 32'(c + 8'h01));
    chk(taken, exp_tk(t, n));
  endtask

  task automatic ret();
    @(posedge core_clk_i);
    ret_cmd <= 1'b1;
    @(posedge core_clk_i);
    ret_cmd <= 1'b0;
  endtask

  task automatic quiet();
    repeat (5) begin
      @(negedge core_clk_i);
      chk(32'(int_req_o), 32'h0);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd(8'h80, 0);
    rd(8'h81, 0);
    rd(8'h82, 0);
    rd(8'h05, 0);
    wr(8'h90, 16'h00ff);
    rd(8'h90, 0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      ix = tbl_num[i] - 7'h10;
      wr({1'b0, ix}, 16'h0044);
      evt(80'h1 << ix, 8'h00);
      if (i >= 5) begin
        quiet();
        wr({1'b0, ix}, 16'h00c4);
      end
      take(1'b0, tbl_num[i]);
      chk(32'(taken[23:0]), 32'(tbl_vec[i]));
      ret();
    end
    $display("node table test done");
    for (int s = 0; s < 4; s++) begin
      seg = 8'(xorshift());
      sp = 2'(s);
      ack_delay <= 2'(xorshift());
      wr(8'h80, {8'h00, seg});
      wr(8'h81, {14'h0000, sp});
      rd(8'h81, sp);
      ix = 7'(xorshift() % 80);
      wr({1'b0, ix}, 16'h00c8);
      take(1'b0, ix + 7'h10);
      ret();
    end
    $display("segment and spacing test done");
    ack_en <= 1'b0;
    la = 4'(xorshift() % 13) + 4'h1;
    lb = la + 4'h1;
    wr(8'h03, {8'h00, 2'b11, la, 2'b00});
    wr(8'h0a, {8'h00, 2'b11, lb, 2'b00});
    wr(8'h0c, {8'h00, 2'b10, 4'hf, 2'b00});
    rd(8'h0a, {2'b11, lb, 2'b00});
    chk(32'(int_trap_num_o), 32'h1a);
    chk(32'(int_level_o), 32'(lb));
    ack_en <= 1'b1;
    take(1'b0, 7'h1a);
    rd(8'h83, lb);
    wr(8'h14, {8'h00, 2'b11, lb, 2'b00});
    quiet();
    wr(8'h1e, 16'h00fc);
    take(1'b0, 7'h2e);
    ret();
    ret();
    take(1'b0, 7'h24);
    ret();
    take(1'b0, 7'h13);
    ret();
    quiet();
    wr(8'h0c, 16'h0000);
    $display("priority test done");
    for (int i = 0; i < 8; i++) begin
      evt('0, 8'h01 << i);
      take(1'b1, i < 4 ? 7'(2 + 2 * i) : 7'h0a);
      ret();
    end
    rd(8'h82, 8'hff);
    wr(8'h82, 16'h0000);
    rd(8'h82, 0);
    evt('0, 8'h01);
    take(1'b1, 7'h02);
    wr(8'h05, 16'h00fc);
    evt('0, 8'h20);
    evt('0, 8'h02);
    quiet();
    ret();
    take(1'b1, 7'h04);
    ret();
    take(1'b1, 7'h0a);
    ret();
    take(1'b0, 7'h15);
    evt('0, 8'h80);
    take(1'b1, 7'h0a);
    ret();
    ret();
    rd(8'h82, 8'ha3);
    $display("trap test done");
    give_verdict();
  end

  initial begin
    repeat (4000) @(posedge core_clk_i);
    failures++;
    give_verdict();
  end
endmodule // tb_intc_vector_core
